// ### logic/sync_serial_pkg.sv
/*
  Constants for the synchronous serial channel: register offsets, field
  positions, reset values and state codes.
  Assumes a single module clock and a plain register port with word-wide data.

*/
package sync_serial_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets (word index on the register port)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PORT = 4'h1;
  localparam logic [3:0] OFS_TXB = 4'h2;
  localparam logic [3:0] OFS_RXB = 4'h3;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_BAUD = 4'h5;

  // control register fields
  localparam int CTRL_WIDTH_POS = 0; // 4 bits: transfer width minus one
  localparam int CTRL_MSB_POS = 4;
  localparam int CTRL_PHASE_POS = 5;
  localparam int CTRL_POL_POS = 6;
  localparam int CTRL_MASTER_POS = 7;
  localparam int CTRL_EN_POS = 8;
  localparam int CTRL_OD_POS = 9;
  localparam int CTRL_SEL_POS = 10;
  localparam int CTRL_HALF_POS = 11;
  localparam int CTRL_BITS = 12;
  localparam logic [11:0] CTRL_RESET = 12'h007;

  // port register: output latches in bits 2:0, directions in bits 5:3
  localparam int PIN_SCLK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PORT_DIR_POS = 3;
  localparam logic [5:0] PORT_RESET = 6'h07;

  // status register fields
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_TXF_POS = 1;
  localparam int STAT_RXF_POS = 2;
  localparam int STAT_ECHO_POS = 3;

  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [3:0] WIDTH_MIN_M1 = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } xfer_state_e;
endpackage

// ### logic/pin_sync.sv
/*
  Two-stage synchroniser for a group of asynchronous pin inputs.
  Assumes inputs may change at any time relative to mclk.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // raw and synchronised levels
  input wire logic [N-1:0] async_in,
  output logic [N-1:0] sync_out
);
  // first stage feeds only the second stage, never any logic
  for (genvar i = 0; i < N; i++) begin : g_bit
    logic meta_r;
    logic hold_r;
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        meta_r <= 1'b1;
        hold_r <= 1'b1;
      end else begin
        meta_r <= async_in[i];
        hold_r <= meta_r;
      end
    end
    assign sync_out[i] = hold_r;
  end
endmodule

// ### logic/sync_serial_channel.sv
/*
  Synchronous serial channel, master or slave, full or half duplex.
  Assumes pins are already split into in/out/enable and that registers are
  reached over a plain one-cycle strobe port on mclk.
*/
`timescale 1ns/100ps
module sync_serial_channel
  import sync_serial_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  // shift clock pin
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // master_out_slave_in_pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  // master_in_slave_out_pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // request lines and busy
  output logic tx_irq_line,
  output logic rx_irq_line,
  output logic transfer_busy_flag
);
  logic [CTRL_BITS-1:0] ctrl_r;
  logic [5:0] port_r;
  logic [15:0] reload_r;
  logic [15:0] baud_cnt_r;
  logic [15:0] tx_buffer_r;
  logic [15:0] rx_buffer_r;
  logic [15:0] sr_r;
  logic [15:0] sr_nxt;
  logic tx_full_r;
  logic rx_full_r;
  logic echo_err_r;
  logic busy_r;
  logic tx_irq_r;
  logic rx_irq_r;
  logic dout_r;
  logic sclk_lvl_r;
  logic sclk_d_r;
  logic [5:0] h_r;
  logic [3:0] idx_r;
  xfer_state_e state_r;
  logic [DATA_W-1:0] rdata_r;
  logic sclk_out_r, sclk_oe_r, mosi_out_r, mosi_oe_r, miso_out_r, miso_oe_r;

  logic [2:0] pins_s;
  logic sclk_s, mosi_s, miso_s;
  logic channel_enable, master_select, clock_phase_select, clock_idle_polarity;
  logic msb_first_select, open_drain, slave_selected, half_duplex;
  logic [3:0] wlast;
  logic [5:0] two_w;
  logic din, ev, smp, shf, done, tick;
  logic wr_ctrl, wr_txb, rd_rxb;

  // every pin input passes two flops first
  pin_sync #(.N(3)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in({miso_in, mosi_in, sclk_in}),
    .sync_out(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[2];

  // control field decode
  assign channel_enable = ctrl_r[CTRL_EN_POS];
  assign master_select = ctrl_r[CTRL_MASTER_POS];
  assign clock_phase_select = ctrl_r[CTRL_PHASE_POS];
  assign clock_idle_polarity = ctrl_r[CTRL_POL_POS];
  assign msb_first_select = ctrl_r[CTRL_MSB_POS];
  assign open_drain = ctrl_r[CTRL_OD_POS];
  assign slave_selected = ctrl_r[CTRL_SEL_POS];
  assign half_duplex = ctrl_r[CTRL_HALF_POS];
  // width field of 0 would mean one bit; clamp to the two-bit minimum
  assign wlast = (ctrl_r[CTRL_WIDTH_POS+:4] < WIDTH_MIN_M1) ? WIDTH_MIN_M1 : ctrl_r[CTRL_WIDTH_POS+:4];
  assign two_w = {1'b0, wlast, 1'b0} + 6'h02;

  // register strobes
  assign wr_ctrl = wr_en && (addr == OFS_CTRL);
  assign wr_txb = wr_en && (addr == OFS_TXB);
  assign rd_rxb = rd_en && (addr == OFS_RXB);

  // bit position in the right-aligned word for transfer step n
  function automatic logic [3:0] phys(input logic [3:0] n, input logic msb, input logic [3:0] last);
    phys = msb ? last - n : n;
  endfunction

  // master input is the receive pin, slave input the transmit pin
  assign din = master_select ? miso_s : mosi_s;
  assign tick = master_select && (state_r == ST_RUN) && (baud_cnt_r == 16'h0000);

  // step events: h_r odd samples, even (non-zero, not last) shifts out
  always_comb begin
    ev = channel_enable && (master_select ? tick : (sclk_s ^ sclk_d_r));
    smp = ev && h_r[0];
    shf = ev && !h_r[0] && (h_r != 6'h00) && (h_r != two_w);
    done = ev && (clock_phase_select ? (h_r == two_w - 6'h01) : (h_r == two_w));
    sr_nxt = sr_r;
    if (smp) begin
      sr_nxt[phys(idx_r, msb_first_select, wlast)] = din;
    end
  end

  // edge history of the synchronised shift clock
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sclk_d_r <= 1'b1; // matches the synchroniser's reset level, so no false edge
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  // configuration registers written by software
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
      port_r <= PORT_RESET;
      reload_r <= BAUD_RESET;
    end else if (wr_en) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata[CTRL_BITS-1:0];
      end
      if (addr == OFS_PORT) begin
        port_r <= wdata[5:0];
      end
      // writing the reload while running upsets the bit timing
      if (addr == OFS_BAUD) begin
        reload_r <= wdata;
      end
    end
  end

  // baud generator only runs while a master transfer is active
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      baud_cnt_r <= BAUD_RESET;
    end else if (state_r != ST_RUN || !master_select) begin
      baud_cnt_r <= reload_r;
    end else if (baud_cnt_r == 16'h0000) begin
      baud_cnt_r <= reload_r;
    end else begin
      baud_cnt_r <= baud_cnt_r - 16'h0001;
    end
  end

  // master clock level: idle polarity, toggled on each step edge except at h_r 0 when clock_phase_select is 0
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sclk_lvl_r <= 1'b1;
    end else if (!channel_enable || state_r == ST_IDLE) begin
      sclk_lvl_r <= clock_idle_polarity;
    end else if (ev && (clock_phase_select ? (h_r < two_w) : (h_r != 6'h00))) begin
      sclk_lvl_r <= ~sclk_lvl_r;
    end
  end

  // transfer engine: buffers, shift register, step counters, flags
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      tx_buffer_r <= 16'h0000;
      tx_full_r <= 1'b0;
      rx_buffer_r <= 16'h0000;
      rx_full_r <= 1'b0;
      sr_r <= 16'h0000;
      dout_r <= 1'b1;
      h_r <= 6'h00;
      idx_r <= 4'h0;
      busy_r <= 1'b0;
      tx_irq_r <= 1'b0;
      rx_irq_r <= 1'b0;
      echo_err_r <= 1'b0;
    end else begin
      tx_irq_r <= 1'b0;
      rx_irq_r <= 1'b0;
      sr_r <= sr_nxt;
      if (wr_txb) begin
        tx_buffer_r <= wdata;
        tx_full_r <= 1'b1;
      end
      // a read clears the full flag; a frame ending now sets it again
      if (rd_rxb) begin
        rx_full_r <= 1'b0;
      end
      if (wr_en && addr == OFS_STAT && wdata[STAT_ECHO_POS]) begin
        echo_err_r <= 1'b0;
      end
      if (smp && half_duplex && (din != dout_r)) begin
        echo_err_r <= 1'b1;
      end
      if (ev) begin
        h_r <= h_r + 6'h01;
      end
      if (ev && master_select && h_r == 6'h00) begin
        dout_r <= sr_r[phys(4'h0, msb_first_select, wlast)];
      end
      if (shf) begin
        idx_r <= idx_r + 4'h1;
        dout_r <= sr_r[phys(idx_r + 4'h1, msb_first_select, wlast)];
      end
      if (!channel_enable) begin
        // disabled: stop at once, data output returns high
        state_r <= ST_IDLE;
        busy_r <= 1'b0;
        dout_r <= 1'b1;
        h_r <= 6'h00;
        idx_r <= 4'h0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            h_r <= (master_select || clock_phase_select) ? 6'h00 : 6'h01;
            idx_r <= 4'h0;
            if (master_select && tx_full_r && !wr_txb) begin
              // master starts from the buffer; first bit waits for a tick
              sr_r <= tx_buffer_r;
              tx_full_r <= 1'b0;
              state_r <= ST_RUN;
              busy_r <= 1'b1;
              tx_irq_r <= 1'b1;
            end else if (!master_select && (sclk_s ^ sclk_d_r)) begin
              // slave starts on the first clock edge, loaded or not
              state_r <= ST_RUN;
              busy_r <= 1'b1;
              tx_irq_r <= 1'b1;
              h_r <= (clock_phase_select ? 6'h00 : 6'h01) + 6'h01;
              if (!clock_phase_select) begin
                sr_r[phys(4'h0, msb_first_select, wlast)] <= din;
              end
            end else if (!master_select && tx_full_r && !wr_txb) begin
              sr_r <= tx_buffer_r;
              tx_full_r <= 1'b0;
              dout_r <= tx_buffer_r[phys(4'h0, msb_first_select, wlast)];
            end
          end
          ST_RUN: begin
            if (done) begin
              rx_buffer_r <= sr_nxt;
              rx_full_r <= 1'b1;
              rx_irq_r <= 1'b1;
              h_r <= (master_select || clock_phase_select) ? 6'h00 : 6'h01;
              idx_r <= 4'h0;
              if (tx_full_r && !wr_txb) begin
                // back-to-back frame from a reloaded buffer
                sr_r <= tx_buffer_r;
                tx_full_r <= 1'b0;
                tx_irq_r <= 1'b1;
                if (!master_select) begin
                  dout_r <= tx_buffer_r[phys(4'h0, msb_first_select, wlast)];
                  state_r <= ST_IDLE;
                end
              end else begin
                // data line keeps its last bit
                state_r <= ST_IDLE;
                busy_r <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  // pin drive: alternate output ANDed with the port latch
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sclk_out_r <= 1'b1;
      sclk_oe_r <= 1'b0;
      mosi_out_r <= 1'b1;
      mosi_oe_r <= 1'b0;
      miso_out_r <= 1'b1;
      miso_oe_r <= 1'b0;
    end else begin
      sclk_out_r <= port_r[PIN_SCLK] & (channel_enable && master_select ? sclk_lvl_r : 1'b1);
      sclk_oe_r <= port_r[PORT_DIR_POS + PIN_SCLK] & master_select;
      mosi_out_r <= port_r[PIN_MOSI] & (channel_enable && master_select ? dout_r : 1'b1);
      mosi_oe_r <= port_r[PORT_DIR_POS + PIN_MOSI] & master_select
                   & (!open_drain | !(port_r[PIN_MOSI] & dout_r));
      // an unselected open-drain slave only ever sends ones
      miso_out_r <= port_r[PIN_MISO]
                    & (channel_enable && !master_select && (slave_selected || !open_drain) ? dout_r : 1'b1);
      miso_oe_r <= port_r[PORT_DIR_POS + PIN_MISO] & !master_select & slave_selected
                   & (!open_drain | !(port_r[PIN_MISO] & dout_r));
    end
  end

  // read data, valid in the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_r <= 16'h0000;
    end else if (rd_en) begin
      unique case (addr)
        OFS_CTRL: rdata_r <= {4'h0, ctrl_r};
        OFS_PORT: rdata_r <= {10'h000, port_r};
        OFS_TXB: rdata_r <= tx_buffer_r;
        OFS_RXB: rdata_r <= rx_buffer_r;
        OFS_STAT: rdata_r <= {12'h000, echo_err_r, rx_full_r, tx_full_r, busy_r};
        OFS_BAUD: rdata_r <= channel_enable ? baud_cnt_r : reload_r;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata = rdata_r;
  assign sclk_out = sclk_out_r;
  assign sclk_oe = sclk_oe_r;
  assign mosi_out = mosi_out_r;
  assign mosi_oe = mosi_oe_r;
  assign miso_out = miso_out_r;
  assign miso_oe = miso_oe_r;
  assign tx_irq_line = tx_irq_r;
  assign rx_irq_line = rx_irq_r;
  assign transfer_busy_flag = busy_r;
endmodule

// ### tb/sync_serial_sva.sv
/*
  Concurrent checks on the serial channel's ports.
  Assumes one mclk domain with a synchronous active-low resetn.
*/
`timescale 1ns/100ps
module sync_serial_sva
  import sync_serial_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rdata,
  // drive enables
  input wire logic sclk_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  // requests and busy
  input wire logic tx_irq_line,
  input wire logic rx_irq_line,
  input wire logic transfer_busy_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // frame start: busy and reload request together
  sequence frame_open;
    $rose(transfer_busy_flag) ##0 tx_irq_line;
  endsequence
  // shortest frame is four ticks, so no end right after a start
  sequence no_end;
    !rx_irq_line [*3];
  endsequence
  clk_owner_a: assert property (sclk_oe |-> !miso_oe) else $error("clock and slave out both on");
  data_owner_a: assert property (miso_oe |-> !mosi_oe) else $error("both data pins driven");
  tx_start_a: assert property ($rose(transfer_busy_flag) |-> frame_open) else $error("start, no tx");
  tx_pulse_a: assert property (tx_irq_line |=> !tx_irq_line) else $error("tx request too long");
  busy_hold_a: assert property (tx_irq_line |=> transfer_busy_flag) else $error("busy not held");
  frame_len_a: assert property (frame_open |=> no_end) else $error("frame too short");
  rx_pulse_a: assert property (rx_irq_line |=> !rx_irq_line) else $error("rx request too long");
  busy_end_a: assert property ($fell(transfer_busy_flag) |-> rx_irq_line || $past(rx_irq_line))
    else $error("busy ended without rx request");
  rd_quiet_a: assert property (!$past(rd_en) || $past(addr) > OFS_BAUD |-> rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule
bind sync_serial_channel sync_serial_sva i_sync_serial_sva (.mclk(mclk), .resetn(resetn), .addr(addr),
  .rd_en(rd_en), .rdata(rdata), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .tx_irq_line(tx_irq_line), .rx_irq_line(rx_irq_line), .transfer_busy_flag(transfer_busy_flag));

// ### tb/spi_peer.sv
/*
  Behavioural selected slave for master frames: idle-low clock, leading edge
  samples, trailing edge shifts.
  Assumes load is pulsed before the master starts a frame.
*/
`timescale 1ns/100ps
module spi_peer (
  // lines from the master
  input wire logic sclk,
  input wire logic mosi,
  // frame setup
  input wire logic load,
  input wire logic [4:0] width,
  input wire logic msb_first,
  input wire logic [15:0] tx_word,
  // reply and captured word
  output logic miso,
  output logic [15:0] rx_word
);
  int cnt = 32;
  // new frame: first bit valid before any edge
  always @(posedge load) begin
    cnt = 0;
    rx_word = 16'h0000;
  end
  // clock is only ever an input here
  always @(posedge sclk) begin
    if (cnt < width) rx_word[msb_first ? width - 1 - cnt : cnt] = mosi;
  end
  always @(negedge sclk) begin
    cnt = cnt + 1;
  end
  // after the frame the line stays driven: show the inverse of the last bit, not a stale bit
  always_comb begin
    if (cnt < width) miso = tx_word[msb_first ? width - 1 - cnt : cnt];
    else miso = ~tx_word[msb_first ? 0 : width - 1];
  end
endmodule

// ### tb/tb_top.sv
/*
  Self-checking bench: register port, master frames against the peer model,
  slave frames against a bench-made 320 ns shift clock.
  Assumes the checker is bound to the channel.
*/
`timescale 1ns/100ps
module tb_top
  import sync_serial_pkg::*;
;
  // clock, reset, register port
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [15:0] v;
  // pins and requests
  logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic tx_irq_line, rx_irq_line, transfer_busy_flag;
  logic tb_sclk = 1'b0;
  logic tb_mosi = 1'b1;
  // peer setup
  logic p_load = 1'b0;
  logic p_msb = 1'b0;
  logic [4:0] p_w = 5'h08;
  logic [15:0] p_tx = 16'h0000;
  logic [15:0] p_rx;
  logic p_miso;
  int n_fail = 0;
  int comparisons = 0;
  // wire levels from whoever drives
  wire sclk_w = sclk_oe ? sclk_out : tb_sclk;
  wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire miso_w = miso_oe ? miso_out : p_miso;

  sync_serial_channel i_sync_serial_channel (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .tx_irq_line(tx_irq_line), .rx_irq_line(rx_irq_line),
    .transfer_busy_flag(transfer_busy_flag));
  spi_peer i_spi_peer (.sclk(sclk_w), .mosi(mosi_w), .load(p_load), .width(p_w), .msb_first(p_msb),
    .tx_word(p_tx), .miso(p_miso), .rx_word(p_rx));

  initial begin
    forever #20 mclk = ~mclk;
  end

  task stop_test();
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // each access starts on a fresh edge, so strobes never flip twice in one step
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  task wait_rx();
    int k;
    for (k = 0; k < 3000 && rx_irq_line !== 1'b1; k++) @(posedge mclk);
    chk(16'(k < 3000), 16'h0001, "no rx request");
  endtask

  task t_regs();
    chk(16'({sclk_oe, mosi_oe, miso_oe, sclk_out, mosi_out, miso_out}), 16'h0007, "pins at reset");
    rd(OFS_CTRL, v);
    chk(v, 16'(CTRL_RESET), "ctrl reset");
    rd(OFS_PORT, v);
    chk(v, 16'(PORT_RESET), "port reset");
    rd(OFS_BAUD, v);
    chk(v, BAUD_RESET, "baud reset");
    wr(4'hF, 16'hFFFF);
    rd(4'hF, v);
    chk(v, 16'h0000, "unmapped read");
  endtask

  task t_master(input logic [3:0] wm1, input logic msb, input logic [15:0] d, input logic [15:0] r);
    logic [16:0] m;
    logic [15:0] c;
    m = (17'h1 << (wm1 + 1)) - 17'h1;
    c = {8'h00, 3'b100, msb, wm1};
    p_w <= 5'(wm1) + 5'h01;
    p_msb <= msb;
    p_tx <= r;
    wr(OFS_PORT, 16'h001E);
    wr(OFS_BAUD, 16'h0003);
    wr(OFS_CTRL, c);
    wr(OFS_CTRL, c | 16'h0100);
    wr(OFS_PORT, 16'h001F);
    // peer restarts only once the clock pin has settled low
    p_load <= 1'b1;
    repeat (2) @(posedge mclk);
    p_load <= 1'b0;
    chk(16'({sclk_oe, mosi_oe, sclk_out}), 16'h0006, "clock idle");
    wr(OFS_TXB, d);
    wait_rx();
    chk(p_rx & m[15:0], d & m[15:0], "peer data");
    rd(OFS_RXB, v);
    chk(v & m[15:0], r & m[15:0], "master data");
    repeat (4) @(posedge mclk);
    chk(16'({sclk_out, mosi_out}), 16'(msb ? d[0] : d[wm1]), "lines after frame");
    wr(OFS_CTRL, c);
    repeat (2) @(posedge mclk);
    chk(16'({sclk_out, mosi_out}), 16'h0003, "lines disabled");
  endtask

  // slave frame on an unrelated 320 ns clock that rests between frames
  task t_slave();
    logic [7:0] sd;
    logic [7:0] st;
    int i;
    sd = 8'h5A;
    st = 8'h96;
    wr(OFS_PORT, 16'h0027);
    wr(OFS_CTRL, 16'h0407);
    // half-duplex echo on: bench data differs from the reply in bits 2, 3, 6 and 7
    wr(OFS_CTRL, 16'h0D07);
    wr(OFS_TXB, 16'(st));
    repeat (4) @(posedge mclk);
    chk(16'({miso_oe, miso_out}), 16'h0002, "slave first bit");
    #7;
    for (i = 0; i < 8; i++) begin
      tb_mosi <= sd[i];
      #160 tb_sclk <= 1'b1;
      #100 chk(16'(miso_out), 16'(st[i]), "slave bit");
      #60 tb_sclk <= 1'b0;
    end
    tb_mosi <= ~tb_mosi;
    @(posedge mclk);
    wait_rx();
    rd(OFS_RXB, v);
    chk(v, 16'(sd), "slave data");
    rd(OFS_STAT, v);
    chk(v, 16'(1 << STAT_ECHO_POS), "echo mismatch missed");
    wr(OFS_STAT, 16'(1 << STAT_ECHO_POS));
    rd(OFS_STAT, v);
    chk(v, 16'h0000, "echo flag not cleared");
    wr(OFS_CTRL, 16'h0107);
    repeat (2) @(posedge mclk);
    chk(16'(miso_oe), 16'h0000, "deselected drives");
  endtask

  task t_off();
    wr(OFS_CTRL, 16'h0087);
    wr(OFS_TXB, 16'h00FF);
    repeat (40) @(posedge mclk);
    chk(16'(transfer_busy_flag), 16'h0000, "disabled started");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_master(4'h7, 1'b0, 16'h00A5, 16'h003C);
    t_master(4'hF, 1'b1, 16'h8E31, 16'h52C7);
    t_master(4'h1, 1'b1, 16'h0002, 16'h0001);
    t_slave();
    t_off();
    stop_test();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #800000;
    n_fail++;
    stop_test();
  end
endmodule
